// File: logic/ssp_consts.svh
// Register offsets, field positions, reset values and frame counts for the serial port
// What this block does
// - Polarity 1 phase 0 idle: clock, select high
// - Master drives clock pad, slave releases it
// - Start: select low, transmit pad enabled
// - Phase 0: data half period, then clock
// - Single word: select high one period later
// - Phase 0 words: select pulsed high between
// - Phase 1: data and first clock edge together
// - Phase 1 words: select stays low throughout
// - Command frame: 8 out, wait, 4-16 in
// - Command format idle: clock low, select high
// - Control byte write starts frame, MSB first
// - Slave latches rising, answers falling after wait
// - Single command frame: select high, word stored
// - Continuous command frames: next byte follows directly
// - Slave samples first bit on first rise
// - Bit rate: clock / (prescale * (1+rate))
// - Prescale even 2-254, rate 0-255
// - Words 4-16 bits, MSB first
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH
// Register byte offsets
`define SSP_OFF_CTRL0     12'h000
`define SSP_OFF_CTRL1     12'h004
`define SSP_OFF_DATA      12'h008
`define SSP_OFF_STATUS    12'h00c
`define SSP_OFF_PRESCALE  12'h010
// Reset values
`define SSP_CTRL0_RST     16'h0000
`define SSP_CTRL1_RST     4'h0
`define SSP_PRESCALE_RST  8'h00
// Control register 1 bit positions
`define SSP_C1_PORT_EN    1
`define SSP_C1_SLAVE      2
`define SSP_C1_SLAVE_OD   3
// Status register bit positions
`define SSP_ST_TX_EMPTY   0
`define SSP_ST_TX_NFULL   1
`define SSP_ST_RX_NEMPTY  2
`define SSP_ST_RX_FULL    3
`define SSP_ST_BUSY       4
// Frame format codes
`define SSP_FRF_SPI       2'h0
`define SSP_FRF_CMD       2'h2
// Word sizes
`define SSP_DSS_MIN       4'h3
`define SSP_MIN_BITS      5'h04
`define SSP_CMD_BITS      8
// Command frame half-period marks: control byte end, response capture base, first response capture
`define SSP_CMD_TX_END    6'(2*`SSP_CMD_BITS)
`define SSP_CMD_CAP_BASE  6'(2*`SSP_CMD_BITS+1)
`define SSP_CMD_FIRST_CAP 6'(2*`SSP_CMD_BITS+3)
`endif

// File: logic/ssp_pkg.sv
// Types shared by the serial port design files
package ssp_pkg;
  // Master frame engine states
  typedef enum logic [1:0] {SSP_IDLE, SSP_ACTIVE, SSP_GAP} ssp_state_t;
  // Control register 0 layout
  typedef struct packed {
    logic [7:0] rateDivider;
    logic       clockPhase;
    logic       clockPolarity;
    logic [1:0] frameFormatSelect;
    logic [3:0] dataSizeSelect;
  } ssp_cfg_t;
  // Pad levels sampled from the pins
  typedef struct packed {
    logic sclk;
    logic fss;
    logic rx;
  } ssp_pin_in_t;
  // Pad levels and enables driven to the pins
  typedef struct packed {
    logic sclk;
    logic sclkOe;
    logic fss;
    logic fssOe;
    logic tx;
    logic txOe;
  } ssp_pin_out_t;
endpackage : ssp_pkg

// File: logic/ssp_fifo.sv
// Flip-flop FIFO used for the transmit and receive word queues
`timescale 1ns/1ps
module ssp_fifo #(
  parameter int WIDTH = 16,  // Word width
  parameter int DEPTH = 8    // Entries, a power of two
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Fill side
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] pushData,
  // Drain side
  input  wire logic             pop,
  output logic      [WIDTH-1:0] popData,
  // Occupancy
  output logic                  empty,
  output logic                  full
);
  localparam int AW = $clog2(DEPTH);

  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("ssp_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];  // Storage
  logic [AW-1:0]    wrPtr;        // Next slot to write
  logic [AW-1:0]    rdPtr;        // Oldest entry
  logic [AW:0]      count;        // Entries held
  logic             doPush;
  logic             doPop;

  // A push into a full queue is dropped, a pop from an empty one ignored
  assign doPush  = push && !full;
  assign doPop   = pop && !empty;
  assign empty   = (count == '0);
  assign full    = (count == (AW+1)'(DEPTH));
  assign popData = mem[rdPtr];

  // Pointers and fill level
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doPush) wrPtr <= wrPtr + 1'b1;
      if (doPop) rdPtr <= rdPtr + 1'b1;
      if (doPush && !doPop) count <= count + 1'b1;
      else if (doPop && !doPush) count <= count - 1'b1;
    end
  end

  // Storage needs no reset; empty guards every read
  always_ff @(posedge clk_sys) begin
    if (doPush) mem[wrPtr] <= pushData;
  end
endmodule : ssp_fifo

// File: logic/ssp_core.sv
// Serial port core: registers, bit-rate strobe, master and slave frame engine
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "ssp_consts.svh"
module ssp_core #(
  parameter int DEPTH = 8  // Entries in each word FIFO
) (
  // System clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // Register port
  input  wire logic [11:0]           regAddr,
  input  wire logic [31:0]           regWdata,
  input  wire logic                  regWr,
  input  wire logic                  regRd,
  output logic      [31:0]           regRdata,
  // Serial pads
  input  wire ssp_pkg::ssp_pin_in_t  padIn,
  output ssp_pkg::ssp_pin_out_t      padOut
);
  // Software-visible configuration
  ssp_pkg::ssp_cfg_t   cfg;        // Rate, phase, polarity, format, size
  logic [3:0]          roleCtrl;   // Enable and role bits
  logic [7:0]          prescale;   // Prescale divisor, kept even

  // Frame engine state
  ssp_pkg::ssp_state_t state;      // Master sequencing
  logic [5:0]          step;       // Half periods in frame, or slave bit count
  logic [15:0]         txShift;    // Outgoing word, next bit at 15
  logic [15:0]         rxShift;    // Incoming bits, newest at 0
  logic                rxPush;     // Word ready for receive FIFO
  logic [15:0]         rxWord;     // Word handed to receive FIFO
  logic                slvFirst;   // Slave still owes its first bit
  logic                sclkPrev;   // Clock pin one cycle ago
  logic                fssPrev;    // Select pin one cycle ago

  // Bit-rate strobe
  logic [6:0]          preCnt;     // Prescale half counter
  logic [7:0]          rateCnt;    // Rate divider counter
  logic                tick;       // Half bit period strobe

  // FIFO wires
  logic                txEmpty;
  logic                txFull;
  logic                rxEmpty;
  logic                rxFull;
  logic [15:0]         txTop;      // Oldest queued transmit word
  logic [15:0]         rxTop;      // Oldest received word
  logic                txPop;
  logic                rxPop;
  logic                txPush;

  // Decoded controls
  logic                portEn;
  logic                isSlave;
  logic                slaveOd;
  logic                isCmd;
  logic                fmtOk;
  logic                slvPol;
  logic                slvPha;
  logic [4:0]          nBits;      // Word length, 4 to 16
  logic [5:0]          twoN;       // Half periods of one word
  logic [5:0]          lastCap;    // Half period of the final command capture
  logic [5:0]          lastBitIdx; // Slave count at the final capture
  logic [5:0]          s;          // Step after this strobe
  logic [15:0]         loadWord;   // Queue head aligned MSB first
  logic [15:0]         nextRx;     // Shifter with the pin bit appended
  logic                masterStart;
  logic                contLoad;
  logic                slvLoad;
  logic                fssFall;
  logic                slvEdge;
  logic                slvCap;
  logic                slvShift;
  logic                busy;
  logic [4:0]          status;

  assign portEn  = roleCtrl[`SSP_C1_PORT_EN];
  assign isSlave = roleCtrl[`SSP_C1_SLAVE];
  assign slaveOd = roleCtrl[`SSP_C1_SLAVE_OD];
  assign isCmd   = (cfg.frameFormatSelect == `SSP_FRF_CMD);
  // The pulsed-select format is not carried; it never starts a frame
  assign fmtOk   = isCmd || (cfg.frameFormatSelect == `SSP_FRF_SPI);

  // Sizes below four bits are served as four
  assign nBits = (cfg.dataSizeSelect < `SSP_DSS_MIN) ? `SSP_MIN_BITS
               : 5'({1'b0, cfg.dataSizeSelect} + 5'h01);
  assign twoN       = {nBits, 1'b0};
  assign lastCap    = `SSP_CMD_CAP_BASE + twoN;
  assign lastBitIdx = {1'b0, nBits} - 6'h01;
  assign s          = step + 6'h01;
  assign nextRx     = {rxShift[14:0], padIn.rx};

  // Master command frames send the low byte; data words and slave replies go out MSB first
  assign loadWord = txEmpty ? 16'h0000
                  : (isCmd && !isSlave) ? {txTop[7:0], 8'h00}
                  : (txTop << (5'h10 - nBits));

  // The command format always runs as polarity 0, phase 0 when slave
  assign slvPol   = isCmd ? 1'b0 : cfg.clockPolarity;
  assign slvPha   = isCmd ? 1'b0 : cfg.clockPhase;
  assign fssFall  = fssPrev && !padIn.fss;
  assign slvEdge  = (padIn.sclk != sclkPrev) && !padIn.fss;
  assign slvCap   = slvEdge && (padIn.sclk ^ slvPol ^ slvPha);
  assign slvShift = slvEdge && !(padIn.sclk ^ slvPol ^ slvPha);

  // Master starts from idle, or after the one-period select pulse
  assign masterStart = portEn && !isSlave && fmtOk && !txEmpty &&
                       (state == ssp_pkg::SSP_IDLE ||
                        (state == ssp_pkg::SSP_GAP && tick && step == 6'h01));
  // Seamless reload: next control byte, or next phase-1 word
  assign contLoad = portEn && !isSlave && state == ssp_pkg::SSP_ACTIVE && tick &&
                    !txEmpty && ((isCmd && s == lastCap + 6'h01) ||
                                 (!isCmd && cfg.clockPhase && s == twoN));
  assign slvLoad  = portEn && isSlave &&
                    (fssFall || (slvCap && step == lastBitIdx && slvPha));
  assign txPop    = masterStart || contLoad || slvLoad;
  assign txPush   = regWr && (regAddr == `SSP_OFF_DATA);
  assign rxPop    = regRd && (regAddr == `SSP_OFF_DATA);
  assign busy     = (state != ssp_pkg::SSP_IDLE) || (portEn && isSlave && !fssPrev);

  // Status word as software sees it
  always_comb begin
    status = '0;
    status[`SSP_ST_TX_EMPTY]  = txEmpty;
    status[`SSP_ST_TX_NFULL]  = !txFull;
    status[`SSP_ST_RX_NEMPTY] = !rxEmpty;
    status[`SSP_ST_RX_FULL]   = rxFull;
    status[`SSP_ST_BUSY]      = busy;
  end

  // Transmit queue: a data write enqueues the low half-word
  ssp_fifo #(
    .WIDTH    (16),
    .DEPTH    (DEPTH)
  ) u_tx_fifo (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .push     (txPush),
    .pushData (regWdata[15:0]),
    .pop      (txPop),
    .popData  (txTop),
    .empty    (txEmpty),
    .full     (txFull)
  );

  // Receive queue: a data read dequeues; overrun words are dropped
  ssp_fifo #(
    .WIDTH    (16),
    .DEPTH    (DEPTH)
  ) u_rx_fifo (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .push     (rxPush),
    .pushData (rxWord),
    .pop      (rxPop),
    .popData  (rxTop),
    .empty    (rxEmpty),
    .full     (rxFull)
  );

  // Register writes; software is expected to disable the port first
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg      <= `SSP_CTRL0_RST;
      roleCtrl <= `SSP_CTRL1_RST;
      prescale <= `SSP_PRESCALE_RST;
    end else if (regWr) begin
      case (regAddr)
        `SSP_OFF_CTRL0:    cfg <= regWdata[15:0];
        `SSP_OFF_CTRL1:    roleCtrl <= regWdata[3:0];
        // Bit 0 is forced low so the divisor stays even
        `SSP_OFF_PRESCALE: prescale <= {regWdata[7:1], 1'b0};
        default: begin
        end
      endcase
    end
  end

  // Read data stands for the one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regRdata <= 32'h0000_0000;
    end else if (regRd) begin
      case (regAddr)
        `SSP_OFF_CTRL0:    regRdata <= {16'h0000, cfg};
        `SSP_OFF_CTRL1:    regRdata <= {28'h000_0000, roleCtrl};
        `SSP_OFF_DATA:     regRdata <= {16'h0000, rxEmpty ? 16'h0000 : rxTop};
        `SSP_OFF_STATUS:   regRdata <= {27'h000_0000, status};
        `SSP_OFF_PRESCALE: regRdata <= {24'h00_0000, prescale};
        default:           regRdata <= 32'h0000_0000;  // Unmapped reads zero
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

  // Half-period strobe every prescale/2 * (rate+1) clocks; restarted at frame start
  // so the first half period after select falls is fixed, one clock longer than the rest
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      preCnt  <= 7'h00;
      rateCnt <= 8'h00;
      tick    <= 1'b0;
    end else if (state == ssp_pkg::SSP_IDLE || masterStart) begin
      preCnt  <= 7'h00;
      rateCnt <= 8'h00;
      tick    <= 1'b0;
    end else begin
      tick <= 1'b0;
      // A zero divisor is served as the least legal one
      if (preCnt >= ((prescale[7:1] == 7'h00) ? 7'h00 : prescale[7:1] - 7'h01)) begin
        preCnt <= 7'h00;
        if (rateCnt == cfg.rateDivider) begin
          rateCnt <= 8'h00;
          tick    <= 1'b1;
        end else begin
          rateCnt <= rateCnt + 8'h01;
        end
      end else begin
        preCnt <= preCnt + 7'h01;
      end
    end
  end

  // Pin history for slave edge detection; pins count as synchronous
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sclkPrev <= 1'b0;
      fssPrev  <= 1'b1;
    end else begin
      sclkPrev <= padIn.sclk;
      fssPrev  <= padIn.fss;
    end
  end

  // Frame engine: drives the pads, shifts both words, feeds the receive queue
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state    <= ssp_pkg::SSP_IDLE;
      step     <= 6'h00;
      txShift  <= 16'h0000;
      rxShift  <= 16'h0000;
      rxPush   <= 1'b0;
      rxWord   <= 16'h0000;
      slvFirst <= 1'b0;
      padOut   <= '0;
      padOut.fss <= 1'b1;
    end else begin
      rxPush <= 1'b0;
      // Master owns clock and select pads, a slave leaves them to the far end
      padOut.sclkOe <= !isSlave;
      padOut.fssOe  <= !isSlave;
      // A slave drives its line only while selected and not output-disabled
      padOut.txOe   <= isSlave ? (!slaveOd && !padIn.fss) : 1'b1;
      // Idle levels, refreshed each cycle so a mode change shows at once
      if (!portEn || isSlave || state == ssp_pkg::SSP_IDLE) begin
        padOut.sclk <= isCmd ? 1'b0 : cfg.clockPolarity;
        padOut.fss  <= 1'b1;
        if (!isSlave || !portEn) padOut.tx <= 1'b0;
      end
      if (!portEn) begin
        // Disabling aborts any frame in flight
        state    <= ssp_pkg::SSP_IDLE;
        step     <= 6'h00;
        slvFirst <= 1'b0;
      end else if (isSlave) begin
        state <= ssp_pkg::SSP_IDLE;
        if (fssFall) begin
          // Selected: load the reply; phase 0 shows its MSB at once
          txShift  <= loadWord;
          rxShift  <= 16'h0000;
          step     <= 6'h00;
          slvFirst <= slvPha;
          if (!slvPha) padOut.tx <= loadWord[15];
        end else if (slvShift) begin
          if (slvFirst) begin
            padOut.tx <= txShift[15];
            slvFirst  <= 1'b0;
          end else begin
            padOut.tx <= txShift[14];
            txShift   <= txShift << 1;
          end
        end else if (slvCap) begin
          rxShift <= nextRx;
          if (step == lastBitIdx) begin
            rxPush  <= 1'b1;
            rxWord  <= nextRx;
            rxShift <= 16'h0000;
            step    <= 6'h00;
            // Phase 1 keeps select low, so the next word loads here
            if (slvPha) begin
              txShift  <= loadWord;
              slvFirst <= 1'b1;
            end
          end else begin
            step <= s;
          end
        end
      end else if (masterStart) begin
        // Select falls and the queue head enters the shifter
        state      <= ssp_pkg::SSP_ACTIVE;
        step       <= 6'h00;
        txShift    <= loadWord;
        rxShift    <= 16'h0000;
        padOut.fss <= 1'b0;
        if (isCmd) padOut.tx <= loadWord[15];
      end else begin
        unique case (state)
          ssp_pkg::SSP_IDLE: begin
          end
          ssp_pkg::SSP_GAP: begin
            // Select held high one bit period so the slave can reload
            if (tick) begin
              if (step == 6'h01) state <= ssp_pkg::SSP_IDLE;
              else step <= s;
            end
          end
          ssp_pkg::SSP_ACTIVE: begin
            if (tick) begin
              step <= s;
              if (isCmd) begin
                // Odd half periods rise, even ones fall; clock rests low after
                padOut.sclk <= s[0] && (s <= lastCap);
                if (!s[0] && s < `SSP_CMD_TX_END) begin
                  padOut.tx <= txShift[14];
                  txShift   <= txShift << 1;
                end
                if (s == `SSP_CMD_TX_END) padOut.tx <= 1'b0;
                // Response captured on rises after the one-clock wait
                if (s[0] && s >= `SSP_CMD_FIRST_CAP && s <= lastCap) begin
                  rxShift <= nextRx;
                end
                if (contLoad) begin
                  // Next control byte follows the response LSB directly
                  rxPush    <= 1'b1;
                  rxWord    <= rxShift;
                  rxShift   <= 16'h0000;
                  txShift   <= loadWord;
                  padOut.tx <= loadWord[15];
                  step      <= 6'h00;
                end
                if (s == lastCap + 6'h02) begin
                  padOut.fss <= 1'b1;
                  rxPush     <= 1'b1;
                  rxWord     <= rxShift;
                  state      <= ssp_pkg::SSP_IDLE;
                end
              end else if (!cfg.clockPhase) begin
                // Phase 0: data first, clock half a period later
                padOut.sclk <= (!s[0] && s <= twoN) ? !cfg.clockPolarity
                                                     : cfg.clockPolarity;
                if (s == 6'h01) begin
                  padOut.tx <= txShift[15];
                end else if (s[0] && s < twoN) begin
                  padOut.tx <= txShift[14];
                  txShift   <= txShift << 1;
                end
                if (!s[0] && s <= twoN) rxShift <= nextRx;
                if (s == twoN) begin
                  rxPush <= 1'b1;
                  rxWord <= nextRx;
                end
                if (s == twoN + 6'h02) begin
                  // One period after the last capture; pulse if more queued
                  padOut.fss <= 1'b1;
                  padOut.tx  <= 1'b0;
                  step       <= 6'h00;
                  state      <= txEmpty ? ssp_pkg::SSP_IDLE : ssp_pkg::SSP_GAP;
                end
              end else begin
                // Phase 1: first edge and data together
                padOut.sclk <= (s[0] && s < twoN) ? !cfg.clockPolarity
                                                   : cfg.clockPolarity;
                if (s == 6'h01) begin
                  padOut.tx <= txShift[15];
                end else if (s[0] && s < twoN) begin
                  padOut.tx <= txShift[14];
                  txShift   <= txShift << 1;
                end
                if (!s[0] && s <= twoN) rxShift <= nextRx;
                if (s == twoN) begin
                  rxPush <= 1'b1;
                  rxWord <= nextRx;
                end
                if (contLoad) begin
                  // Select stays low; next word follows seamlessly
                  txShift <= loadWord;
                  rxShift <= 16'h0000;
                  step    <= 6'h00;
                end
                if (s == twoN + 6'h02) begin
                  padOut.fss <= 1'b1;
                  padOut.tx  <= 1'b0;
                  state      <= ssp_pkg::SSP_IDLE;
                end
              end
            end
          end
        endcase
      end
    end
  end
endmodule : ssp_core

// File: tb/ssp_assertions.sv
// Checker for the serial port pads against shadowed configuration
`timescale 1ns/1ps
module ssp_assertions (
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  rst,
  // Register port
  input wire logic [11:0]           regAddr,
  input wire logic [31:0]           regWdata,
  input wire logic                  regWr,
  input wire logic                  regRd,
  input wire logic [31:0]           regRdata,
  // Pads
  input wire ssp_pkg::ssp_pin_in_t  padIn,
  input wire ssp_pkg::ssp_pin_out_t padOut
);
  logic [15:0] cr0;      // Control 0 shadow
  logic [3:0]  cr1;      // Control 1 shadow
  logic [7:0]  pre;      // Prescale shadow
  logic [1:0]  quiet;    // Cycles since a config write; pads lag a write
  logic [15:0] gap;      // Cycles since the clock pad last moved
  logic        prevSclk; // Clock pad one cycle ago
  wire logic [15:0] half = {9'h0, (pre[7:1] == 7'h0) ? 7'h1 : pre[7:1]} * (cr0[15:8] + 16'h1);
  wire logic        ok   = (quiet == 2'h3) && !cr1[2];
  // Configuration shadows
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {cr0, cr1, pre, quiet} <= 30'h0;
    end else if (regWr && (regAddr == 12'h0 || regAddr == 12'h4 || regAddr == 12'h10)) begin
      quiet <= 2'h0;
      cr0   <= (regAddr == 12'h0) ? regWdata[15:0] : cr0;
      cr1   <= (regAddr == 12'h4) ? regWdata[3:0] : cr1;
      pre   <= (regAddr == 12'h10) ? regWdata[7:0] : pre;
    end else begin
      quiet <= (quiet == 2'h3) ? quiet : quiet + 2'h1;
    end
  end
  // Spacing of clock pad edges, saturating
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {prevSclk, gap} <= 17'h0;
    end else begin
      prevSclk <= padOut.sclk;
      gap      <= (padOut.sclk != prevSclk) ? 16'h1 : gap + {15'h0, gap != 16'hffff};
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_master_clk_pad: assert property (ok |-> padOut.sclkOe)
    else $error("master clock pad released");
  a_slave_clk_pad: assert property (quiet == 2'h3 && cr1[2] |-> !padOut.sclkOe)
    else $error("slave drives clock pad");
  a_idle_clk_level: assert property (ok && padOut.fss && !cr0[4] |->
    padOut.sclk == (cr0[5] ? 1'b0 : cr0[6])) else $error("idle clock level wrong");
  a_start_tx_pad: assert property (ok && $fell(padOut.fss) |-> padOut.txOe)
    else $error("transmit pad off at frame start");
  a_lead_half: assert property (ok && $fell(padOut.fss) |=> $stable(padOut.sclk))
    else $error("clock moved with select fall");
  a_frame_min_len: assert property (ok && $fell(padOut.fss) |-> (!padOut.fss)[*8])
    else $error("frame too short");
  a_bit_rate_gap: assert property (ok && $changed(padOut.sclk) |-> gap >= half)
    else $error("clock edge too early");
  a_disabled_idle: assert property (ok && !cr1[1] |-> padOut.fss)
    else $error("select low while disabled");
endmodule : ssp_assertions
bind ssp_core ssp_assertions ssp_assertions_inst (.clk_sys(clk_sys), .rst(rst),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .padIn(padIn), .padOut(padOut));

// File: tb/ssp_slave_model.sv
// Off-chip serial slave: answers SPI words and command frames
`timescale 1ns/1ps
module ssp_slave_model (
  // Pins seen by the slave
  input wire logic        padSclk,
  input wire logic        padFss,
  input wire logic        tx,
  // Mode and reply
  input wire logic        pol,
  input wire logic        pha,
  input wire logic        cmd,
  input wire logic [4:0]  nbits,
  input wire logic [15:0] reply,
  output logic            rx,
  output logic [15:0]     got
);
  int idx;   // Next reply bit
  int rises; // Capture edges in this frame
  initial {rx, got, idx, rises} = 0;
  // Select fall loads the reply, phase 0 outside command frames shows the MSB at once
  always @(negedge padFss) begin
    idx = int'(nbits) - 1;
    rises = 0;
    got = 16'h0;
    if (!pha && !cmd) begin
      rx = reply[idx];
      idx--;
    end
  end
  // Released line flips so no stale bit survives
  always @(posedge padFss) rx = ~rx;
  // Capture and drive edges; command answers after one wait clock
  always @(padSclk) begin
    if (!padFss) begin
      if (cmd ? padSclk : (padSclk ^ pol ^ pha)) begin
        if (!cmd || rises < 8) got = {got[14:0], tx};
        rises++;
      end else if (!cmd || rises >= 9) begin
        if (idx >= 0) rx = reply[idx];
        else rx = ~rx;
        idx--;
      end
    end
  end
endmodule : ssp_slave_model

// File: tb/testbench.sv
// Self-checking bench for the serial port core
`timescale 1ns/1ps
module testbench;
  logic                  clk_sys, rst, regWr, regRd, rxLine;
  logic [11:0]           regAddr;
  logic [31:0]           regWdata, regRdata;
  logic [15:0]           reply, got, cfg;
  logic [4:0]            nbits;
  ssp_pkg::ssp_pin_in_t  padIn;
  ssp_pkg::ssp_pin_out_t padOut;
  int                    errors, num_checks;
  // Released pads are pulled high
  assign padIn = {padOut.sclkOe ? padOut.sclk : 1'b1, padOut.fssOe ? padOut.fss : 1'b1, rxLine};
  ssp_core #(.DEPTH(8)) ssp_core_inst (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .padIn(padIn),
    .padOut(padOut));
  ssp_slave_model ssp_slave_model_inst (.padSclk(padIn.sclk), .padFss(padIn.fss), .tx(padOut.tx),
    .pol(cfg[6]), .pha(cfg[7]), .cmd(cfg[5]), .nbits(nbits), .reply(reply), .rx(rxLine), .got(got));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [31:0] act, input logic [31:0] exp, input string what);
    num_checks++;
    if (act !== exp) begin
      errors++;
      $display("unexpected at %0t: %s %h not %h", $time, what, act, exp);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {regWr, regAddr, regWdata} <= {1'b1, a, d};
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_sys);
    {regRd, regAddr} <= {1'b1, a};
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(posedge clk_sys);
    check(regRdata, exp, what);
  endtask : rdc
  // Disable, pick role, prescale, control 0, enable
  task automatic setup(input logic [31:0] role, input logic [7:0] pre, input logic [15:0] c0);
    cfg = c0;
    wr(12'h004, 32'h0);
    wr(12'h004, role);
    wr(12'h010, {24'h0, pre});
    wr(12'h000, {16'h0, c0});
    wr(12'h004, role | 32'h2);
  endtask : setup
  // One word out and in; measures one clock half period
  task automatic frame(input logic [15:0] c0, input logic [7:0] pre, input logic [15:0] word,
                       input logic [15:0] resp, input logic [4:0] nb, input int half);
    logic s;
    int   t;
    setup(32'h0, pre, c0);
    {reply, nbits} = {resp, nb};
    wr(12'h008, {16'h0, word});
    while (padOut.fss !== 1'b0) @(posedge clk_sys);
    s = padOut.sclk;
    while (padOut.sclk === s) @(posedge clk_sys);
    {s, t} = {padOut.sclk, 32'h0};
    while (padOut.sclk === s) begin
      @(posedge clk_sys);
      t++;
    end
    check(t, half, "half period");
    while (padOut.fss !== 1'b1) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    check({16'h0, got}, {16'h0, word}, "word sent");
    rdc(12'h008, {16'h0, resp}, "word received");
  endtask : frame
  // Two queued words; counts select rises over 300 clocks
  task automatic burst(input logic [15:0] c0, input int rises);
    logic p;
    int   r;
    setup(32'h0, 8'h02, c0);
    wr(12'h008, 32'ha5);
    wr(12'h008, 32'h5a);
    r = 0;
    repeat (300) begin
      p = padOut.fss;
      @(posedge clk_sys);
      r += int'(padOut.fss && !p);
    end
    check(r, rises, "select rises");
  endtask : burst
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    wrap_up();
  end
  initial begin
    {rst, regWr, regRd, regAddr, regWdata, reply, cfg, nbits} = {1'b1, 83'h0};
    {errors, num_checks} = 0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    rdc(12'h00c, 32'h3, "status reset");
    rdc(12'h000, 32'h0, "control reset");
    rdc(12'h014, 32'h0, "unmapped");
    frame(16'h0147, 8'h02, 16'h00a5, 16'h003c, 5'd8, 2);
    frame(16'h00cf, 8'h06, 16'hc3a5, 16'h5a0f, 5'd16, 3);
    frame(16'h0027, 8'h02, 16'h0096, 16'h005b, 5'd8, 1);
    burst(16'h0047, 2);
    burst(16'h00c7, 1);
    setup(32'h4, 8'h02, 16'h0147);
    repeat (3) @(posedge clk_sys);
    check({31'h0, padOut.sclkOe}, 32'h0, "slave clock pad");
    wrap_up();
  end
endmodule : testbench
